//--- csg_params.svh
// Constants for the core slowdown and module clock gate block
`ifndef CSG_PARAMS_SVH
`define CSG_PARAMS_SVH
// Clock divider control word field positions
`define CSG_FULL_SPEED_ON_IRQ_BIT 15
`define CSG_RATIO_HI 14
`define CSG_RATIO_LO 12
`define CSG_SLOWDOWN_EN_BIT 11
`define CSG_CTRL_RESET 16'h0000
// Ratio code at reset selects 1:1
`define CSG_RATIO_RESET 3'h0
// Number of gated peripheral modules
`define CSG_NUM_MODULES 8
// Module-disable bits after reset: all clear
`define CSG_GATE_RESET 8'h00
// Gate change delay, in instruction cycles
`define CSG_GATE_DELAY_ICYC 1
// Widest divide counter: 2**7 - 1
`define CSG_DIV_MAX 7'h7F
`endif

//--- csg_pkg.sv
// Types for the core slowdown and module clock gate block
`default_nettype none
package csg_pkg;
  typedef logic [2:0] csg_ratio_t;
  typedef logic [6:0] csg_count_t;
  typedef enum logic [1:0] {
    CSG_FULL = 2'b00,
    CSG_SLOW = 2'b01,
    CSG_IRQ_FULL = 2'b10
  } csg_mode_t;
endpackage : csg_pkg
`default_nettype wire

//--- csg_gate_if.sv
// Interface between the top module and the module gate stage
`timescale 1ns/10ps
`default_nettype none
`include "csg_params.svh"
interface csg_gate_if;
  logic [`CSG_NUM_MODULES-1:0] disable_req;
  logic [`CSG_NUM_MODULES-1:0] present;
  logic [`CSG_NUM_MODULES-1:0] sw_enable;
  logic instr_tick;
  logic [`CSG_NUM_MODULES-1:0] clk_en;
  logic [`CSG_NUM_MODULES-1:0] access_ok;
  modport ctrl (output disable_req, present, sw_enable, instr_tick, input clk_en, access_ok);
  modport gate (input disable_req, present, sw_enable, instr_tick, output clk_en, access_ok);
endinterface : csg_gate_if
`default_nettype wire

//--- csg_module_gate.sv
// Per-module clock gate with one instruction cycle of delay
`timescale 1ns/10ps
`default_nettype none
`include "csg_params.svh"
module csg_module_gate (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Gate controls and results
  csg_gate_if.gate g
);
  // ==========================================================
  // Per-module pipeline
  genvar gi;
  generate
    for (gi = 0; gi < `CSG_NUM_MODULES; gi++) begin : g_mod
      logic dis_q;
      logic dis_d;
      logic run_q;
      logic run_d;
      // Disable bit is taken at the next instruction boundary
      always_comb begin
        dis_d = dis_q;
        if (g.instr_tick) begin
          dis_d = g.disable_req[gi];
        end
      end
      // Module runs only if present, not disabled and self enabled
      always_comb begin
        run_d = g.present[gi] & ~dis_d & g.sw_enable[gi];
      end
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          dis_q <= 1'b0;
          run_q <= 1'b0;
        end else begin
          dis_q <= dis_d;
          run_q <= run_d;
        end
      end
      // Clock stops and registers go dead while disabled
      assign g.clk_en[gi] = run_q;
      assign g.access_ok[gi] = g.present[gi] & ~dis_q;
    end
  endgenerate
endmodule : csg_module_gate
`default_nettype wire

//--- csg_core_div.sv
// Core clock enable divider, 2**n ratio
`timescale 1ns/10ps
`default_nettype none
`include "csg_params.svh"
module csg_core_div (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_slow,
  input wire csg_pkg::csg_ratio_t i_ratio,
  // Result
  output logic o_core_en
);
  csg_pkg::csg_count_t cnt_q;
  csg_pkg::csg_count_t cnt_d;
  csg_pkg::csg_count_t limit;
  logic en_q;
  logic en_d;
  // ==========================================================
  // Counter derived from the same clock keeps phases aligned
  always_comb begin
    limit = csg_pkg::csg_count_t'((8'h01 << i_ratio) - 8'h01);
    cnt_d = cnt_q + 7'h01;
    en_d = 1'b0;
    if (!i_slow || cnt_q >= limit) begin
      cnt_d = 7'h00;
      en_d = 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= 7'h00;
      en_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end
  assign o_core_en = en_q;
endmodule : csg_core_div
`default_nettype wire

//--- csg_top.sv
// Core slowdown and peripheral module clock gating, top level
// Notes on behaviour
// - Setting slowdown enable bit 11 starts core slowdown.
// - Ratio field bits 14:12 picks one of eight ratios; reset gives 1:1.
// - Only the core clock is divided; peripherals keep full speed.
// - Divided core clock stays aligned with the peripheral clock.
// - With bit 15 set, an interrupt returns the core to full speed.
// - With bit 15 clear, interrupts leave slowdown untouched.
// - Disable bit stops all clocks of that peripheral.
// - Disabled peripheral ignores writes; its reads are invalid.
// - Peripheral runs only if present and not disabled.
// - After reset all disable bits of present peripherals are clear.
// - Setting a disable bit takes effect after one instruction cycle.
// - Clearing it enables after one instruction cycle, if self enabled.
`timescale 1ns/10ps
`default_nettype none
`include "csg_params.svh"
module csg_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Clock divider control word write
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_wdata,
  // Interrupt event from the interrupt controller
  input wire logic i_irq,
  // Module gate controls
  input wire logic [`CSG_NUM_MODULES-1:0] i_gate_wr_data,
  input wire logic i_gate_wr,
  input wire logic [`CSG_NUM_MODULES-1:0] i_present,
  input wire logic [`CSG_NUM_MODULES-1:0] i_sw_enable,
  // Clock enables and module access
  output logic o_core_clk_en,
  output logic o_periph_clk_en,
  output logic [`CSG_NUM_MODULES-1:0] o_module_clk_en,
  output logic [`CSG_NUM_MODULES-1:0] o_module_access_ok,
  // Status
  output logic [15:0] o_clock_divider_ctrl,
  output logic [`CSG_NUM_MODULES-1:0] o_module_clock_gate,
  output logic o_slow_active
);
  logic full_speed_on_irq_q;
  logic full_speed_on_irq_d;
  logic cpu_slowdown_enable_q;
  logic cpu_slowdown_enable_d;
  csg_pkg::csg_ratio_t ratio_q;
  csg_pkg::csg_ratio_t ratio_d;
  logic [`CSG_NUM_MODULES-1:0] gate_q;
  logic [`CSG_NUM_MODULES-1:0] gate_d;
  csg_pkg::csg_mode_t mode_q;
  csg_pkg::csg_mode_t mode_d;
  logic core_en;
  logic tick_q;
  logic tick_d;
  logic [15:0] ctrl_view;
  logic [`CSG_NUM_MODULES-1:0] mclk_q;
  logic [`CSG_NUM_MODULES-1:0] macc_q;
  csg_gate_if gif ();

  // ==========================================================
  // Control word: software write, hardware clear of slowdown
  always_comb begin
    full_speed_on_irq_d = full_speed_on_irq_q;
    cpu_slowdown_enable_d = cpu_slowdown_enable_q;
    ratio_d = ratio_q;
    if (i_ctrl_wr) begin
      full_speed_on_irq_d = i_ctrl_wdata[`CSG_FULL_SPEED_ON_IRQ_BIT];
      cpu_slowdown_enable_d = i_ctrl_wdata[`CSG_SLOWDOWN_EN_BIT];
      ratio_d = i_ctrl_wdata[`CSG_RATIO_HI:`CSG_RATIO_LO];
    end
    // Interrupt return wins over a same-cycle write of the enable
    if (i_irq && full_speed_on_irq_d) begin
      cpu_slowdown_enable_d = 1'b0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      full_speed_on_irq_q <= 1'b0;
      cpu_slowdown_enable_q <= 1'b0;
      ratio_q <= `CSG_RATIO_RESET;
    end else begin
      full_speed_on_irq_q <= full_speed_on_irq_d;
      cpu_slowdown_enable_q <= cpu_slowdown_enable_d;
      ratio_q <= ratio_d;
    end
  end

  // ==========================================================
  // Mode tracking for status
  always_comb begin
    mode_d = csg_pkg::CSG_FULL;
    unique case (mode_q)
      csg_pkg::CSG_FULL, csg_pkg::CSG_SLOW: begin
        if (cpu_slowdown_enable_q) begin
          mode_d = csg_pkg::CSG_SLOW;
        end
        // Without irq return the slowdown simply continues
        if (i_irq && full_speed_on_irq_q && cpu_slowdown_enable_q) begin
          mode_d = csg_pkg::CSG_IRQ_FULL;
        end
      end
      csg_pkg::CSG_IRQ_FULL: begin
        mode_d = cpu_slowdown_enable_q ? csg_pkg::CSG_SLOW : csg_pkg::CSG_FULL;
      end
      default: mode_d = csg_pkg::CSG_FULL;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= csg_pkg::CSG_FULL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // Core clock divider; peripherals never see it
  csg_core_div u_div (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_slow(cpu_slowdown_enable_q),
    .i_ratio(ratio_q),
    .o_core_en(core_en)
  );

  // ==========================================================
  // Instruction boundary is one core clock enable
  always_comb begin
    tick_d = core_en;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  // ==========================================================
  // Module disable bits, written by software
  always_comb begin
    gate_d = gate_q;
    if (i_gate_wr) begin
      gate_d = i_gate_wr_data;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gate_q <= `CSG_GATE_RESET;
    end else begin
      gate_q <= gate_d;
    end
  end

  // Gate stage hookup
  assign gif.disable_req = gate_q;
  assign gif.present = i_present;
  assign gif.sw_enable = i_sw_enable;
  assign gif.instr_tick = tick_q;
  csg_module_gate u_gate (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .g(gif.gate)
  );

  // ==========================================================
  // Output registers
  always_comb begin
    ctrl_view = `CSG_CTRL_RESET;
    ctrl_view[`CSG_FULL_SPEED_ON_IRQ_BIT] = full_speed_on_irq_q;
    ctrl_view[`CSG_RATIO_HI:`CSG_RATIO_LO] = ratio_q;
    ctrl_view[`CSG_SLOWDOWN_EN_BIT] = cpu_slowdown_enable_q;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_core_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b0;
      o_clock_divider_ctrl <= `CSG_CTRL_RESET;
      o_module_clock_gate <= `CSG_GATE_RESET;
      o_slow_active <= 1'b0;
      mclk_q <= '0;
      macc_q <= '0;
    end else begin
      o_core_clk_en <= core_en;
      o_periph_clk_en <= 1'b1;
      o_clock_divider_ctrl <= ctrl_view;
      o_module_clock_gate <= gate_q;
      o_slow_active <= (mode_q == csg_pkg::CSG_SLOW);
      mclk_q <= gif.clk_en;
      macc_q <= gif.access_ok;
    end
  end
  assign o_module_clk_en = mclk_q;
  assign o_module_access_ok = macc_q;
endmodule : csg_top
`default_nettype wire

//--- csg_sva.sv
// Checker for the slowdown and module gate block
`timescale 1ns/10ps
`default_nettype none
module csg_sva (
  // Watched ports
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_wdata,
  input wire logic i_irq,
  input wire logic [7:0] i_gate_wr_data,
  input wire logic i_gate_wr,
  input wire logic [7:0] i_present,
  input wire logic [7:0] i_sw_enable,
  input wire logic o_core_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic [7:0] o_module_clk_en,
  input wire logic [7:0] o_module_access_ok,
  input wire logic [15:0] o_clock_divider_ctrl,
  input wire logic [7:0] o_module_clock_gate,
  input wire logic o_slow_active
);
  // ====
  // Pulse gap and settle counters; spacing is judged only after a long quiet run
  logic [7:0] gap_q, gap_d, set_q, set_d;
  always_comb begin
    gap_d = o_core_clk_en ? 8'h01 : gap_q + 8'h01;
    set_d = (i_ctrl_wr | i_irq) ? 8'h00 : set_q + {7'h00, set_q != 8'hFF};
  end
  always_ff @(posedge i_core_clk) begin
    gap_q <= i_rst ? 8'h00 : gap_d;
    set_q <= i_rst ? 8'h00 : set_d;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence settled;
    (!o_slow_active && $stable(o_module_clock_gate) && $stable(i_sw_enable))[*6];
  endsequence
  // ====
  chk_periph_on: assert property (!$past(i_rst) |-> o_periph_clk_en)
    else $error("peripheral clock stopped");
  chk_ctrl_back: assert property (i_ctrl_wr && !i_irq ##1 (!i_ctrl_wr && !i_irq)[*3]
    |-> o_clock_divider_ctrl == ($past(i_ctrl_wdata, 3) & 16'hF800)) else $error("readback");
  chk_irq_full: assert property (o_clock_divider_ctrl[15] && i_irq && !$past(i_ctrl_wr)
    && !i_ctrl_wr && !$past(i_ctrl_wr, 2) ##1 (!i_ctrl_wr)[*3] |-> !o_slow_active)
    else $error("irq");
  chk_irq_none: assert property (!o_clock_divider_ctrl[15] && o_slow_active && i_irq
    && !i_ctrl_wr && !$past(i_ctrl_wr) && !$past(i_ctrl_wr, 2) |=> o_slow_active)
    else $error("irq ended slow");
  chk_core_gap: assert property (o_core_clk_en && set_q == 8'hFF |-> gap_q ==
    (o_slow_active ? 8'h01 << o_clock_divider_ctrl[14:12] : 8'h01)) else $error("gap");
  chk_rst_clear: assert property ($past(i_rst) |-> o_module_clock_gate == 8'h00
    && o_clock_divider_ctrl == 16'h0000) else $error("reset values");
  chk_gate_en: assert property (settled |-> o_module_clk_en ==
    (~o_module_clock_gate & i_present & i_sw_enable)) else $error("module clock");
  chk_gate_acc: assert property (settled |-> o_module_access_ok ==
    (~o_module_clock_gate & i_present)) else $error("access");
  chk_gate_delay: assert property ((!i_gate_wr)[*5] ##1 i_gate_wr && !o_slow_active
    ##1 (!i_gate_wr)[*2] |-> o_module_access_ok == $past(o_module_access_ok, 2))
    else $error("gate too early");
  cov_slow: cover property (o_slow_active && o_clock_divider_ctrl[14:12] == 3'h7);
  cov_irq: cover property (o_clock_divider_ctrl[15] && i_irq);
  cov_gate: cover property (i_gate_wr && i_gate_wr_data != 8'h00);
endmodule : csg_sva
bind csg_top csg_sva u_sva (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_ctrl_wr(i_ctrl_wr),
  .i_ctrl_wdata(i_ctrl_wdata),
  .i_irq(i_irq),
  .i_gate_wr_data(i_gate_wr_data),
  .i_gate_wr(i_gate_wr),
  .i_present(i_present),
  .i_sw_enable(i_sw_enable),
  .o_core_clk_en(o_core_clk_en),
  .o_periph_clk_en(o_periph_clk_en),
  .o_module_clk_en(o_module_clk_en),
  .o_module_access_ok(o_module_access_ok),
  .o_clock_divider_ctrl(o_clock_divider_ctrl),
  .o_module_clock_gate(o_module_clock_gate),
  .o_slow_active(o_slow_active)
);
`default_nettype wire

//--- csg_periph_model.sv
// Peripheral model behind one module gate
`timescale 1ns/10ps
`default_nettype none
module csg_periph_model (
  // Clock and gate
  input wire logic i_core_clk,
  input wire logic i_clk_en,
  input wire logic i_access_ok,
  // Register access
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  logic [15:0] reg_q;
  // Write lands only with clock and access granted
  always_ff @(posedge i_core_clk) begin
    if (i_wr && i_clk_en && i_access_ok) begin
      reg_q <= i_wdata;
    end
  end
  // Disabled reads give garbage, not the stored value
  assign o_rdata = i_access_ok ? reg_q : ~reg_q;
endmodule : csg_periph_model
`default_nettype wire

//--- csg_top_tb.sv
// Testbench for the slowdown and module gate block
`timescale 1ns/10ps
`default_nettype none
module csg_top_tb;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_ctrl_wr = 1'b0, i_irq = 1'b0, i_gate_wr = 1'b0;
  logic [15:0] i_ctrl_wdata = 16'h0000, p_wdata = 16'h0000, p_rdata, o_clock_divider_ctrl;
  logic [7:0] i_gate_wr_data = 8'h00, i_present = 8'hEF, i_sw_enable = 8'h7F;
  logic [7:0] o_module_clk_en, o_module_access_ok, o_module_clock_gate;
  logic o_core_clk_en, o_periph_clk_en, o_slow_active, p_wr = 1'b0;
  int n_fail = 0, checks_done = 0, cnt;
  csg_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ctrl_wr(i_ctrl_wr),
    .i_ctrl_wdata(i_ctrl_wdata), .i_irq(i_irq), .i_gate_wr_data(i_gate_wr_data),
    .i_gate_wr(i_gate_wr), .i_present(i_present), .i_sw_enable(i_sw_enable),
    .o_core_clk_en(o_core_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_module_clk_en(o_module_clk_en), .o_module_access_ok(o_module_access_ok),
    .o_clock_divider_ctrl(o_clock_divider_ctrl), .o_module_clock_gate(o_module_clock_gate),
    .o_slow_active(o_slow_active));
  csg_periph_model u_per (.i_core_clk(i_core_clk), .i_clk_en(o_module_clk_en[0]),
    .i_access_ok(o_module_access_ok[0]), .i_wr(p_wr), .i_wdata(p_wdata), .o_rdata(p_rdata));
  // ====
  // Clock at 50 ns
  always #25 i_core_clk = ~i_core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    // Look after the edge's updates so a just-launched value is seen
    #1;
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // One-cycle write: 0 control word, 1 gate bits, 2 peripheral
  task automatic put(input int k, input logic [15:0] d);
    @(posedge i_core_clk);
    {i_ctrl_wr, i_gate_wr, p_wr} <= 3'b100 >> k;
    {i_ctrl_wdata, i_gate_wr_data, p_wdata} <= {d, d[7:0], d};
    @(posedge i_core_clk);
    {i_ctrl_wr, i_gate_wr, p_wr} <= 3'b000;
  endtask : put
  // Waits for readback first so the pulse meets the stored bits
  task automatic irq();
    cyc(3);
    i_irq <= 1'b1;
    cyc(1);
    i_irq <= 1'b0;
    cyc(5);
  endtask : irq
  task automatic count(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge i_core_clk);
      chk(o_periph_clk_en, 1'b1, "periph");
      cnt += int'(o_core_clk_en);
    end
  endtask : count
  task automatic test_done();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // ====
  // Hang guard
  initial begin
    cyc(20000);
    n_fail++;
    test_done();
  end
  // ====
  // Main sequence
  initial begin
    for (int r = 0; r < 2; r++) begin
      i_rst <= 1'b1;
      cyc(3);
      i_rst <= 1'b0;
      cyc(4);
      chk(o_clock_divider_ctrl, 16'h0000, "ctrl");
      chk(o_module_clock_gate, 8'h00, "gate");
      chk(o_module_clk_en, 8'h6F, "mod en");
      chk(o_module_access_ok, 8'hEF, "acc");
      count(64);
      chk(cnt[15:0], 16'd64, "full");
      for (int n = 0; n < 8; n++) begin
        put(0, {1'b0, n[2:0], 12'h800});
        cyc(300);
        count(256);
        chk(cnt[15:0], 16'd256 >> n, "ratio");
        chk(o_clock_divider_ctrl, {1'b0, n[2:0], 12'h800}, "back");
        chk(o_slow_active, 1'b1, "slow");
      end
      // Back on a rising edge before reset is driven again
      cyc(1);
    end
    put(0, 16'h2800);
    irq();
    chk(o_slow_active, 1'b1, "irq");
    put(0, 16'hA800);
    irq();
    chk(o_slow_active, 1'b0, "irq return");
    chk(o_clock_divider_ctrl, 16'hA000, "irq back");
    count(64);
    chk(cnt[15:0], 16'd64, "irq full");
    put(2, 16'h5A5A);
    cyc(2);
    chk(p_rdata, 16'h5A5A, "pw");
    put(1, 16'h0081);
    cyc(1);
    chk(o_module_access_ok, 8'hEF, "early");
    cyc(4);
    chk(o_module_clk_en, 8'h6E, "off");
    chk(o_module_access_ok, 8'h6E, "acc off");
    chk(o_module_clock_gate, 8'h81, "gate back");
    put(2, 16'h1234);
    cyc(2);
    chk(p_rdata, 16'hA5A5, "inv");
    put(1, 16'h0000);
    cyc(6);
    chk(p_rdata, 16'h5A5A, "kept");
    chk(o_module_access_ok, 8'hEF, "acc back");
    chk(o_module_clk_en, 8'h6F, "on again");
    // Own enable changes on a rising edge like every other input
    cyc(1);
    i_sw_enable <= 8'hFF;
    cyc(6);
    chk(o_module_clk_en, 8'hEF, "sw");
    test_done();
  end
endmodule : csg_top_tb
`default_nettype wire
